// ---- bench/tb.sv ----
// Self-checking bench for the camera trigger front end.
// Assumes trig_source drives the pins and a 50 MHz clock; counts are kept in few us.
`timescale 1ns/1ps
`include "trig_cfg.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin bad_count++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module tb import trig_pkg::*;;
	typedef struct packed {logic [7:0] a; logic [31:0] v;} row_s;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic inv = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic [31:0] rdata_o;
	logic [31:0] d;
	logic ext1, ext2, cc1, pgen, exposing_o, readout_o, ready_o, strobe1_o, strobe2_o;
	logic ov_seen = 1'b0;
	int bad_count = 0;
	int compares = 0;
	int exp_n = 0;
	int s1_n = 0;
	int s2_n = 0;
	int n;
	row_s rows [11] = '{'{`CTRL_OFS, `CTRL_RST}, '{`HOLDOFF_OFS, `HOLDOFF_RST},
		'{`GLITCH_OFS, `GLITCH_RST}, '{`EXP_DELAY_OFS, `EXP_DELAY_RST},
		'{`FRAMES_OFS, `FRAMES_RST}, '{`STB_DELAY_OFS, `STB_DELAY_RST},
		'{`STB_WIDTH_OFS, `STB_WIDTH_RST}, '{`EXPOSURE_OFS, `EXPOSURE_RST},
		'{`READOUT_OFS, `READOUT_RST}, '{`SW_TRIG_OFS, 32'h0}, '{8'h2C, 32'h0}};

	always #10 clk_i = ~clk_i;

	camera_trigger_control DUT (.clk_i, .rst_n_i, .ext1_i(ext1), .ext2_i(ext2), .cc1_i(cc1),
		.pulse_gen_i(pgen), .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .exposing_o,
		.readout_o, .ready_o, .strobe1_o, .strobe2_o);
	trig_source src (.clk_i, .inv_i(inv), .ext1_o(ext1), .ext2_o(ext2), .cc1_o(cc1),
		.pulse_o(pgen));

	// Event counters, cleared between tests on the falling edge
	always @(posedge exposing_o) exp_n++;
	always @(posedge strobe1_o) s1_n++;
	always @(posedge strobe2_o) s2_n++;
	always @(negedge clk_i) if (exposing_o && readout_o) ov_seen = 1'b1;

	// ====
	// Register port tasks
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		d = rdata_o;
	endtask : rd
	task automatic clr;
		@(negedge clk_i);
		exp_n = 0;
		s1_n = 0;
		s2_n = 0;
		ov_seen = 1'b0;
	endtask : clr
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop
	// Bounded wait for ready (w=0) or exposure (w=1); n returns the cycles taken
	task automatic wait_for(input bit w, input int lim);
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while ((w ? exposing_o : ready_o) !== 1'b1 && n < lim);
		if ((w ? exposing_o : ready_o) !== 1'b1) begin
			bad_count++;
			$display("CHECK FAILED wait %0d exp 1 got 0", w);
			report_and_stop();
		end
	endtask : wait_for

	// ====
	// Main sequence
	initial begin
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		foreach (rows[i]) begin
			rd(rows[i].a);
			`CHK("reset value", rows[i].v, d)
		end
		`CHK("free run", 1, exp_n)
		`CHK("free run ready", 1'b0, ready_o)
		$display("test reset done");
		wr(`HOLDOFF_OFS, 32'h2);
		wr(`EXPOSURE_OFS, 32'h3);
		wr(`READOUT_OFS, 32'h2);
		wr(`EXP_DELAY_OFS, 32'h2);
		wr(`STB_DELAY_OFS, 32'h1);
		wr(`STB_WIDTH_OFS, 32'h2);
		for (int s = 0; s < 4; s++) begin
			wr(`CTRL_OFS, 32'h0B | (s << 7));
			wait_for(0, 60000);
			clr();
			wr(`SW_TRIG_OFS, 32'h1);
			wait_for(1, 3000);
			`CHK("exp delay", 1'b1, n inside {[45:110]})
			repeat (500) @(posedge clk_i);
			`CHK("strobe1", s[0], s1_n == 1)
			`CHK("strobe2", s[1], s2_n == 1)
			`CHK("frames", 1, exp_n)
			`CHK("no overlap", 1'b0, ov_seen)
		end
		$display("test strobes done");
		for (int s = 0; s < 5; s++) begin
			if (s == 3)
				continue;
			wr(`CTRL_OFS, 32'h8 | s);
			wait_for(0, 3000);
			clr();
			src.pulse(s == 4 ? 0 : 4, 300);
			repeat (300) @(posedge clk_i);
			`CHK("other pin", 0, exp_n)
			src.pulse(s, 300);
			`CHK("own pin", 1, exp_n)
		end
		$display("test sources done");
		inv <= 1'b1;
		wr(`CTRL_OFS, 32'h28);
		repeat (600) @(posedge clk_i);
		wait_for(0, 3000);
		fork
			src.pulse(0, 400);
		join_none
		wait_for(1, 3000);
		`CHK("falling edge", 1'b1, n < 200)
		repeat (500) @(posedge clk_i);
		wr(`GLITCH_OFS, 32'h3);
		wait_for(0, 3000);
		clr();
		src.pulse(0, 100);
		repeat (300) @(posedge clk_i);
		`CHK("short pulse", 0, exp_n)
		src.pulse(0, 300);
		repeat (200) @(posedge clk_i);
		`CHK("long pulse", 1, exp_n)
		$display("test edge and glitch done");
		for (int ov = 0; ov < 2; ov++) begin
			wr(`CTRL_OFS, 32'h0B | (ov << 6));
			wait_for(0, 3000);
			clr();
			wr(`SW_TRIG_OFS, 32'h1);
			repeat (150) @(posedge clk_i);
			wr(`SW_TRIG_OFS, 32'h1);
			repeat (800) @(posedge clk_i);
			`CHK("overlap", ov + 1, exp_n)
		end
		$display("test overlap done");
		wr(`FRAMES_OFS, 32'h3);
		wait_for(0, 3000);
		clr();
		wr(`SW_TRIG_OFS, 32'h1);
		repeat (1500) @(posedge clk_i);
		`CHK("frame count", 3, exp_n)
		$display("test frames done");
		wr(`FRAMES_OFS, 32'h1);
		wr(`READOUT_OFS, 32'h8);
		wr(`CTRL_OFS, 32'h1B);
		wait_for(0, 3000);
		clr();
		repeat (2) begin
			wait_for(0, 3000);
			wr(`SW_TRIG_OFS, 32'h1);
			repeat (20) @(posedge clk_i);
		end
		repeat (400) @(posedge clk_i);
		`CHK("fast overlap", 1'b1, ov_seen)
		$display("test fast done");
		wr(`READOUT_OFS, 32'h2);
		wr(`CTRL_OFS, 32'h20B);
		wait_for(0, 3000);
		clr();
		wr(`SW_TRIG_OFS, 32'h1);
		repeat (1500) @(posedge clk_i);
		`CHK("unbounded frames", 1'b1, exp_n > 4)
		$display("test unbounded done");
		report_and_stop();
	end
endmodule : tb

// ---- bench/trig_props.sv ----
// Port checker for the camera trigger front end.
// Assumes it is bound onto camera_trigger_control.
`timescale 1ns/1ps
`include "trig_cfg.svh"
module trig_props import trig_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic exposing_o,
	input wire logic readout_o,
	input wire logic ready_o,
	input wire logic strobe1_o,
	input wire logic strobe2_o
);
	ctrl_s ctrl_r;
	// ====
	// Shadow of the control word, so rules can see mode and strobe choice
	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			ctrl_r <= ctrl_s'(`CTRL_RST);
		else if (wr_i && addr_i == `CTRL_OFS)
			ctrl_r <= ctrl_s'(wdata_i[9:0]);
	end

	// Decodes kept apart so each property stays short
	wire sw_go = wr_i && addr_i == `SW_TRIG_OFS && wdata_i[0] && ready_o;
	wire sw_mode = ctrl_r.src == SRC_SW && ctrl_r.triggered;
	wire rd_zero = addr_i[1:0] != 2'h0 || addr_i > `STATUS_OFS || addr_i == `SW_TRIG_OFS;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// ====
	// Assertions
	chk_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0)
		else $error("read data not zero outside a read");
	chk_rd_unmapped: assert property (rd_i && rd_zero |=> rdata_o == 32'h0)
		else $error("unmapped or command read not zero");
	chk_strobe1_off: assert property (
		!ctrl_r.strobe_sel[0] && !$past(ctrl_r.strobe_sel[0]) |-> !strobe1_o)
		else $error("first strobe while not selected");
	chk_strobe2_off: assert property (
		!ctrl_r.strobe_sel[1] && !$past(ctrl_r.strobe_sel[1]) |-> !strobe2_o)
		else $error("second strobe while not selected");
	chk_ready_freerun: assert property (
		!ctrl_r.triggered && !$past(ctrl_r.triggered) |-> !ready_o)
		else $error("ready shown in free running mode");
	chk_ready_busy: assert property (exposing_o |-> !ready_o)
		else $error("ready shown during exposure");
	chk_sw_start: assert property (sw_go && sw_mode |-> ##[1:4] !ready_o)
		else $error("software trigger did not start a cycle");
	chk_holdoff_min: assert property (
		$fell(ready_o) && ctrl_r.triggered |=> !ready_o [*8])
		else $error("ready returned inside holdoff");
	chk_read_after_exp: assert property (
		$rose(readout_o) && !ctrl_r.fast |->
		$past(exposing_o, 1) || $past(exposing_o, 2) || $past(exposing_o, 3))
		else $error("standard readout without exposure first");

	cov_sw_go: cover property (sw_go && sw_mode);
	cov_fast_overlap: cover property (exposing_o && readout_o);
	cov_both_strobes: cover property (strobe1_o && strobe2_o);
endmodule : trig_props

bind camera_trigger_control trig_props chk (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
	.rdata_o, .exposing_o, .readout_o, .ready_o, .strobe1_o, .strobe2_o);

// ---- bench/trig_source.sv ----
// Model of the trigger sources outside the block: two pins, CC1 and pulse generator.
// Assumes pins are plain driven levels; inv_i sets the idle level high.
`timescale 1ns/1ps
module trig_source (
	input wire logic clk_i,
	input wire logic inv_i,
	output logic ext1_o,
	output logic ext2_o,
	output logic cc1_o,
	output logic pulse_o
);
	logic [4:0] act_r = 5'h00;
	assign {ext2_o, cc1_o, pulse_o, ext1_o} = {act_r[4], act_r[2:0]} ^ {4{inv_i}};

	// One active pulse on the pin of source code idx, cyc clocks wide
	task automatic pulse(input int idx, input int cyc);
		@(posedge clk_i);
		act_r[idx] <= 1'b1;
		repeat (cyc) @(posedge clk_i);
		act_r[idx] <= 1'b0;
	endtask : pulse
endmodule : trig_source

// ---- logic/camera_trigger_control.sv ----
// Trigger front end: source select, filtering, overlap handling, exposure sequence, strobes.
// Assumes pins arrive asynchronously; the pulse generator and register port share clk_i.
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "trig_cfg.svh"
module camera_trigger_control import trig_pkg::*; #(
	parameter int TW = 24,
	parameter int HW = 16
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ext1_i,
	input wire logic ext2_i,
	input wire logic cc1_i,
	input wire logic pulse_gen_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output logic exposing_o,
	output logic readout_o,
	output logic ready_o,
	output logic strobe1_o,
	output logic strobe2_o
);
	// ==========================================================
	// Registers
	ctrl_s ctrl_r;
	logic [HW-1:0] holdoff_r;
	logic [HW-1:0] glitch_r;
	logic [TW-1:0] exp_delay_r;
	logic [HW-1:0] frames_cfg_r;
	logic [TW-1:0] stb_delay_r;
	logic [HW-1:0] stb_width_r;
	logic [TW-1:0] exposure_r;
	logic [TW-1:0] readout_r;
	logic sw_pulse_r;

	// Address decode
	wire wr_ctrl = wr_i && (addr_i == `CTRL_OFS);
	wire wr_hold = wr_i && (addr_i == `HOLDOFF_OFS);
	wire wr_glitch = wr_i && (addr_i == `GLITCH_OFS);
	wire wr_edly = wr_i && (addr_i == `EXP_DELAY_OFS);
	wire wr_frames = wr_i && (addr_i == `FRAMES_OFS);
	wire wr_sdly = wr_i && (addr_i == `STB_DELAY_OFS);
	wire wr_swid = wr_i && (addr_i == `STB_WIDTH_OFS);
	wire wr_exp = wr_i && (addr_i == `EXPOSURE_OFS);
	wire wr_rdo = wr_i && (addr_i == `READOUT_OFS);
	wire wr_sw = wr_i && (addr_i == `SW_TRIG_OFS) && wdata_i[`SW_TRIG_BIT];

	// Configuration writes
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ctrl_r <= ctrl_s'(`CTRL_RST);
			holdoff_r <= `HOLDOFF_RST;
			glitch_r <= `GLITCH_RST;
			exp_delay_r <= `EXP_DELAY_RST;
			frames_cfg_r <= `FRAMES_RST;
		end else begin
			if (wr_ctrl) ctrl_r <= ctrl_s'(wdata_i[`CTRL_W-1:0]);
			if (wr_hold) holdoff_r <= wdata_i[HW-1:0];
			if (wr_glitch) glitch_r <= wdata_i[HW-1:0];
			if (wr_edly) exp_delay_r <= wdata_i[TW-1:0];
			if (wr_frames) frames_cfg_r <= wdata_i[HW-1:0];
		end
	end

	// Timing writes; software trigger is a one-cycle pulse
	// software trigger command
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			stb_delay_r <= `STB_DELAY_RST;
			stb_width_r <= `STB_WIDTH_RST;
			exposure_r <= `EXPOSURE_RST;
			readout_r <= `READOUT_RST;
			sw_pulse_r <= 1'b0;
		end else begin
			if (wr_sdly) stb_delay_r <= wdata_i[TW-1:0];
			if (wr_swid) stb_width_r <= wdata_i[HW-1:0];
			if (wr_exp) exposure_r <= wdata_i[TW-1:0];
			if (wr_rdo) readout_r <= wdata_i[TW-1:0];
			sw_pulse_r <= wr_sw;
		end
	end

	// ==========================================================
	// Microsecond tick
	localparam int TICK_N = `TICK_CYCLES;
	logic [7:0] tick_cnt_r;
	logic tick_r;
	wire tick_wrap = (tick_cnt_r == 8'(TICK_N - 1));

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			tick_cnt_r <= 8'h00;
			tick_r <= 1'b0;
		end else begin
			tick_cnt_r <= tick_wrap ? 8'h00 : tick_cnt_r + 8'h01;
			tick_r <= tick_wrap;
		end
	end

	// ==========================================================
	// Pin synchronisers; first stage is read only by the second
	logic [2:0] meta_r;
	logic [2:0] sync_r;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			meta_r <= 3'h0;
			sync_r <= 3'h0;
		end else begin
			meta_r <= {cc1_i, ext2_i, ext1_i};
			sync_r <= meta_r;
		end
	end

	// ==========================================================
	// Source select and active level
	logic src_lvl;
	always_comb begin
		unique case (ctrl_r.src)
			SRC_EXT1: src_lvl = sync_r[0];
			SRC_PGEN: src_lvl = pulse_gen_i;
			SRC_CC1: src_lvl = sync_r[2];
			SRC_EXT2: src_lvl = sync_r[1];
			default: src_lvl = 1'b0;
		endcase
	end

	// Falling edge select inverts the level so the active edge is always a rise
	// edge polarity
	wire act = src_lvl ^ ctrl_r.falling;
	wire pin_src = (ctrl_r.src != SRC_SW);

	// Glitch timer reloads while inactive and fires once the level holds long enough.
	// One extra tick unless zero: the first tick may land anywhere in the current microsecond
	wire [HW:0] g_val = (glitch_r == '0) ? '0 : {1'b0, glitch_r} + (HW+1)'(1);
	wire g_done;
	us_timer #(.W(HW + 1)) u_glitch (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.tick_i(tick_r),
		.load_i(!act),
		.clr_i(1'b0),
		.val_i(g_val),
		.busy_o(),
		.done_o(g_done)
	);

	wire pin_fire = pin_src && act && g_done;

	// ==========================================================
	// Qualification, holdoff and overlap
	seq_state_e st_r;
	seq_state_e st_nxt;
	logic [HW-1:0] frames_r;
	logic [HW-1:0] frames_nxt;
	wire hold_busy;
	wire idle = (st_r == ST_IDLE);

	wire trg = ctrl_r.triggered && !hold_busy && (pin_fire || (!pin_src && sw_pulse_r));
	wire accept = trg && (idle || ctrl_r.overlap_accept);

	us_timer #(.W(HW)) u_holdoff (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.tick_i(tick_r),
		.load_i(accept),
		.clr_i(1'b0),
		.val_i(holdoff_r),
		.busy_o(hold_busy),
		.done_o()
	);

	// ==========================================================
	// Sequence timers
	logic dly_load;
	logic exp_load;
	logic rd_load;
	wire d_done;
	wire e_done;
	wire r_done;
	wire r_busy;

	us_timer #(.W(TW)) u_exp_delay (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.tick_i(tick_r),
		.load_i(dly_load),
		.clr_i(1'b0),
		.val_i(exp_delay_r),
		.busy_o(),
		.done_o(d_done)
	);

	us_timer #(.W(TW)) u_expose (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.tick_i(tick_r),
		.load_i(exp_load),
		.clr_i(accept),
		.val_i(exposure_r),
		.busy_o(),
		.done_o(e_done)
	);

	// Only a restart of a busy cycle cancels a readout still in flight;
	// an idle accept in fast mode must leave the previous readout running
	wire abort = accept && !idle;
	us_timer #(.W(TW)) u_readout (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.tick_i(tick_r),
		.load_i(rd_load),
		.clr_i(abort),
		.val_i(readout_r),
		.busy_o(r_busy),
		.done_o(r_done)
	);

	// More frames wanted after this readout
	wire more = !ctrl_r.triggered || ctrl_r.unbounded_frame_count || (frames_r > 16'h0001);

	// ==========================================================
	// Sequence next state
	always_comb begin
		st_nxt = st_r;
		frames_nxt = frames_r;
		dly_load = 1'b0;
		exp_load = 1'b0;
		rd_load = 1'b0;
		if (accept) begin
			st_nxt = ST_DELAY;
			dly_load = 1'b1;
			frames_nxt = frames_cfg_r;
		end else begin
			unique case (st_r)
				ST_IDLE: if (!ctrl_r.triggered) begin
					st_nxt = ST_EXPOSE;
					exp_load = 1'b1;
				end
				ST_DELAY: if (d_done) begin
					st_nxt = ST_EXPOSE;
					exp_load = 1'b1;
				end
				ST_EXPOSE: if (e_done) begin
					rd_load = 1'b1;
					st_nxt = ctrl_r.fast ? ST_IDLE : ST_READ;
				end
				ST_READ: if (r_done) begin
					if (more) begin
						st_nxt = ST_EXPOSE;
						exp_load = 1'b1;
						frames_nxt = frames_r - 16'h0001;
					end else begin
						st_nxt = ST_IDLE;
					end
				end
				default: st_nxt = ST_IDLE;
			endcase
		end
	end

	// Sequence state
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_r <= ST_IDLE;
			frames_r <= 16'h0000;
		end else begin
			st_r <= st_nxt;
			frames_r <= frames_nxt;
		end
	end

	// ==========================================================
	// Strobe: delay, then width, both in microseconds
	wire s_delay_done;
	wire s_on;

	us_timer #(.W(TW)) u_stb_delay (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.tick_i(tick_r),
		.load_i(accept),
		.clr_i(1'b0),
		.val_i(stb_delay_r),
		.busy_o(),
		.done_o(s_delay_done)
	);

	us_timer #(.W(HW)) u_stb_width (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.tick_i(tick_r),
		.load_i(s_delay_done),
		.clr_i(accept),
		.val_i(stb_width_r),
		.busy_o(s_on),
		.done_o()
	);

	wire stb1 = s_on && ctrl_r.strobe_sel[0];
	wire stb2 = s_on && ctrl_r.strobe_sel[1];

	// ==========================================================
	// Register read mux; unmapped addresses read zero
	wire [31:0] status = {frames_r, 9'h000, hold_busy, r_busy, idle, st_r};
	wire [31:0] rd_mux =
		(addr_i == `CTRL_OFS) ? 32'(ctrl_r) :
		(addr_i == `HOLDOFF_OFS) ? 32'(holdoff_r) :
		(addr_i == `GLITCH_OFS) ? 32'(glitch_r) :
		(addr_i == `EXP_DELAY_OFS) ? 32'(exp_delay_r) :
		(addr_i == `FRAMES_OFS) ? 32'(frames_cfg_r) :
		(addr_i == `STB_DELAY_OFS) ? 32'(stb_delay_r) :
		(addr_i == `STB_WIDTH_OFS) ? 32'(stb_width_r) :
		(addr_i == `EXPOSURE_OFS) ? 32'(exposure_r) :
		(addr_i == `READOUT_OFS) ? 32'(readout_r) :
		(addr_i == `STATUS_OFS) ? status : 32'h0000_0000;

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) rdata_o <= 32'h0000_0000;
		else rdata_o <= rd_i ? rd_mux : 32'h0000_0000;
	end

	// ==========================================================
	// Registered outputs, one cycle behind the state
	// ready indication
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			exposing_o <= 1'b0;
			readout_o <= 1'b0;
			ready_o <= 1'b0;
			strobe1_o <= 1'b0;
			strobe2_o <= 1'b0;
		end else begin
			exposing_o <= (st_r == ST_EXPOSE);
			readout_o <= r_busy;
			ready_o <= idle && ctrl_r.triggered && !hold_busy;
			strobe1_o <= stb1;
			strobe2_o <= stb2;
		end
	end
endmodule : camera_trigger_control

// ---- logic/trig_cfg.svh ----
// Constants of the camera trigger front end: offsets, field positions, resets, timing.
// Assumes a 50 MHz clock and a word-aligned plain register port.
// Operation
// - Trigger comes from one selected source only
// - Software command starts a trigger cycle
// - Free running captures frames without waiting
// - Triggered mode waits for a qualified trigger
// - Standard mode exposes first, then reads out
// - Fast mode exposes during previous readout
// - Exposure starts on selected rising/falling edge
// - Ignore overlap discards triggers while busy
// - Accept overlap aborts and restarts the cycle
// - Retrigger holdoff window after accepted trigger
// - Glitch filter rejects too short pulses
// - Programmable delay from edge to exposure
// - Frames per trigger or unbounded count; standard mode only, fast mode takes one frame per trigger
// - Strobe on none, first, second or both
// - Strobe delayed from edge by programmable time
// - Strobe position and duration in microseconds
// - Ready output paces the external source
`ifndef TRIG_CFG_SVH
`define TRIG_CFG_SVH

// ==========================================================
// Register offsets (byte addresses)
`define CTRL_OFS 8'h00
`define HOLDOFF_OFS 8'h04
`define GLITCH_OFS 8'h08
`define EXP_DELAY_OFS 8'h0C
`define FRAMES_OFS 8'h10
`define STB_DELAY_OFS 8'h14
`define STB_WIDTH_OFS 8'h18
`define EXPOSURE_OFS 8'h1C
`define READOUT_OFS 8'h20
`define SW_TRIG_OFS 8'h24
`define STATUS_OFS 8'h28

// ==========================================================
// Field positions
`define CTRL_W 10
`define SW_TRIG_BIT 0
`define ST_READY_BIT 4
`define ST_RDBUSY_BIT 5
`define ST_HOLD_BIT 6
`define ST_FRAMES_LSB 16

// ==========================================================
// Reset values
`define CTRL_RST 10'h000
`define HOLDOFF_RST 16'h000F
`define GLITCH_RST 16'h0000
`define EXP_DELAY_RST 24'h00_0000
`define FRAMES_RST 16'h0001
`define STB_DELAY_RST 24'h00_0000
`define STB_WIDTH_RST 16'h0001
`define EXPOSURE_RST 24'h00_03E8
`define READOUT_RST 24'h00_03E8

// ==========================================================
// Timing
`define CLK_PERIOD_NS 20
`define TICK_PERIOD_NS 1000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// ---- logic/trig_pkg.sv ----
// Types shared by the trigger front end.
// Assumes trig_cfg.svh is on the include path.
package trig_pkg;
	`include "trig_cfg.svh"

	// ==========================================================
	// Trigger source codes
	typedef enum logic [2:0] {
		SRC_EXT1 = 3'h0,
		SRC_PGEN = 3'h1,
		SRC_CC1 = 3'h2,
		SRC_SW = 3'h3,
		SRC_EXT2 = 3'h4
	} trig_src_e;

	// Strobe output selection
	typedef enum logic [1:0] {
		STB_OFF = 2'h0,
		STB_ONE = 2'h1,
		STB_TWO = 2'h2,
		STB_BOTH = 2'h3
	} strobe_sel_e;

	// Capture sequence states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_DELAY = 4'b0010,
		ST_EXPOSE = 4'b0100,
		ST_READ = 4'b1000
	} seq_state_e;

	// Control word, MSB first
	typedef struct packed {
		logic unbounded_frame_count;
		strobe_sel_e strobe_sel;
		logic overlap_accept;
		logic falling;
		logic fast;
		logic triggered;
		trig_src_e src;
	} ctrl_s;
endpackage : trig_pkg

// ---- logic/us_timer.sv ----
// Loadable down-counter advanced by the microsecond tick.
// Assumes tick_i is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
module us_timer #(
	parameter int W = 16
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic tick_i,
	input wire logic load_i,
	input wire logic clr_i,
	input wire logic [W-1:0] val_i,
	output logic busy_o,
	output logic done_o
);
	logic [W-1:0] cnt_r;
	logic run_r;

	// Done in the cycle the count has run out
	assign done_o = run_r && (cnt_r == '0);
	assign busy_o = run_r;

	// ==========================================================
	// Counter; clear beats load so an abort always wins
	// tick driven count
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || clr_i) begin
			run_r <= 1'b0;
			cnt_r <= '0;
		end else if (load_i) begin
			run_r <= 1'b1;
			cnt_r <= val_i;
		end else if (done_o) begin
			run_r <= 1'b0;
		end else if (run_r && tick_i) begin
			cnt_r <= cnt_r - W'(1);
		end
	end
endmodule : us_timer
